// [rtl/rstfs_top.sv]
// reset generator and fail-safe latch for the module processor core
// Behaviour
// RULE1: power-up holds reset and halt low 130 ms after supplies good
// RULE2: external reset holds ext reset, reset and halt low 24 clocks min
// RULE3: supply low pulls monitor, reset, halt low; hold 130 ms after recovery
// RULE4: drive processor reset and halt only through open-drain outputs
// RULE5: processor watchdog output low sets the fail-safe latch; the code sets it only in the run state
// RULE6: while latched, transmitter disabled and isolated power shut down
// RULE7: latch stays set until power-on or external reset only
// RULE8: isolated power enable stays off until processor leaves reset
// RULE9: fail-safe forces data and clock transceivers to receive direction
// RULE10: slot select together with slot reset acts as external reset
// RULE11: external reset and watchdog inputs synchronised to core clock
`timescale 1ns/1ps
`default_nettype none
module rstfs_top #(
    parameter int unsigned HOLD_CYCLES = rstfs_pkg::HOLD_CYC
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              supply_good_in,
    input  wire logic              slot_select_in,
    input  wire logic              slot_reset_in,
    input  wire logic              watchdog_expired_n_in,
    input  wire logic              cpu_tx_en_n_in,
    input  wire logic              cpu_reset_n_in,
    input  wire logic              cpu_halt_n_in,
    output var rstfs_pkg::rstfs_od_t cpu_reset_od_out,
    output var rstfs_pkg::rstfs_od_t cpu_halt_od_out,
    output logic                   ext_reset_n_out,
    output logic                   power_mon_n_out,
    output logic                   failsafe_active_out,
    output logic                   failsafe_active_n_out,
    output logic                   isolated_power_on_n_out,
    output logic                   xcvr_tx_en_out
);
    import rstfs_pkg::*;

    // every check below runs on the core clock and sleeps during reset
    default clocking chk_clk @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    typedef struct packed {
        rstfs_state_t     state;
        logic [CNT_W-1:0] cnt;
        logic             fs;
        logic             hold;
        logic             ext_hold;
        logic             pmon_low;
        logic             iso_on_n;
        logic             tx_en;
        logic             sup_sync1;
        logic             sup_sync2;
        logic             sup_sync3;
        logic             sup_q;
    } rstfs_core_t;

    localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYCLES);

    rstfs_core_t st_ff;
    rstfs_core_t nxt_st;
    logic        ext_req_n;
    logic        ext_sync_n;
    logic        wdog_sync_n;
    logic        reset_pin_seen_n;
    logic        tx_req_seen_n;

    // slot select and slot reset together form the external reset request
    assign ext_req_n = ~(slot_select_in & slot_reset_in); // [RULE10]

    // pin-domain inputs are filtered before any decision uses them
    rstfs_sync3 u_sync_ext (                    // [RULE11]
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (ext_req_n),
        .sync_out   (ext_sync_n)
    );

    rstfs_sync3 u_sync_wdog (                   // [RULE11]
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (watchdog_expired_n_in),
        .sync_out   (wdog_sync_n)
    );

    rstfs_sync3 u_sync_rstpin (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (cpu_reset_n_in),
        .sync_out   (reset_pin_seen_n)
    );

    // processor transmit request comes from its own clock, so it is filtered
    rstfs_sync3 u_sync_tx (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (cpu_tx_en_n_in),
        .sync_out   (tx_req_seen_n)
    );

    // sequencer: supply watch, external reset window, latch, isolated power
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.sup_sync1 = supply_good_in;
        nxt_st.sup_sync2 = st_ff.sup_sync1;
        nxt_st.sup_sync3 = st_ff.sup_sync2;
        if (st_ff.sup_sync2 == st_ff.sup_sync3) begin
            nxt_st.sup_q = st_ff.sup_sync3;
        end
        if (st_ff.cnt != CNT_ZERO) begin
            nxt_st.cnt = st_ff.cnt - CNT_ONE;
        end
        unique case (st_ff.state)
            RSTFS_ST_PWR: begin
                // counter reloads while supply is bad, so 130 ms runs from recovery
                nxt_st.hold     = 1'b1;                   // [RULE1] [RULE3]
                nxt_st.pmon_low = ~st_ff.sup_q;           // [RULE3]
                if (!st_ff.sup_q) begin
                    nxt_st.cnt = HOLD_LD;                 // [RULE1] [RULE3]
                end else if (st_ff.cnt == CNT_ONE) begin
                    nxt_st.state = RSTFS_ST_RUN;
                    nxt_st.hold  = 1'b0;
                end
            end
            RSTFS_ST_EXT: begin
                nxt_st.hold     = 1'b1;
                nxt_st.ext_hold = 1'b1;                   // [RULE2]
                if (!ext_sync_n) begin
                    nxt_st.cnt = EXT_CYC;                 // [RULE2]
                end else if (st_ff.cnt == CNT_ONE) begin
                    nxt_st.state    = RSTFS_ST_RUN;
                    nxt_st.hold     = 1'b0;
                    nxt_st.ext_hold = 1'b0;
                end
            end
            RSTFS_ST_RUN: begin
                nxt_st.hold     = 1'b0;
                nxt_st.ext_hold = 1'b0;
                nxt_st.pmon_low = 1'b0;
            end
            default: begin
                nxt_st.state = RSTFS_ST_PWR;
            end
        endcase
        // brown-out outranks an external reset; a running external hold is
        // kept to the end of the power hold rather than cut short
        if (!st_ff.sup_q) begin
            nxt_st.state    = RSTFS_ST_PWR;              // [RULE3]
            nxt_st.hold     = 1'b1;
            nxt_st.pmon_low = 1'b1;
            nxt_st.cnt      = HOLD_LD;
        end else if (!ext_sync_n) begin
            nxt_st.hold     = 1'b1;
            nxt_st.ext_hold = 1'b1;                      // [RULE2]
            // a long power count is never traded for the short external one
            if (st_ff.state != RSTFS_ST_PWR || st_ff.cnt < EXT_CYC) begin
                nxt_st.state = RSTFS_ST_EXT;             // [RULE1]
                nxt_st.cnt   = EXT_CYC;
            end
        end
        // latch: watchdog sets, only a supply loss or external reset clears
        if (!wdog_sync_n && st_ff.state == RSTFS_ST_RUN) begin
            nxt_st.fs = 1'b1;                             // [RULE5] [RULE7]
        end else if (!ext_sync_n || !st_ff.sup_q) begin
            nxt_st.fs = 1'b0;                             // [RULE7]
        end
        // isolated power waits for the processor reset pin to rise
        nxt_st.iso_on_n = st_ff.hold | ~reset_pin_seen_n;  // [RULE8]
        nxt_st.iso_on_n = nxt_st.iso_on_n | nxt_st.fs;    // [RULE6]
        nxt_st.tx_en    = ~tx_req_seen_n & ~st_ff.hold;
        nxt_st.tx_en    = nxt_st.tx_en & ~nxt_st.fs;      // [RULE6] [RULE9]
    end

    // reset value mirrors a power-on hold with a full count pending
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff.state     <= RSTFS_ST_PWR;
            st_ff.cnt       <= HOLD_LD;
            st_ff.fs        <= 1'b0;
            st_ff.hold      <= 1'b1;
            st_ff.ext_hold  <= 1'b0;
            st_ff.pmon_low  <= 1'b1;
            st_ff.iso_on_n  <= 1'b1;
            st_ff.tx_en     <= 1'b0;
            st_ff.sup_sync1 <= 1'b0;
            st_ff.sup_sync2 <= 1'b0;
            st_ff.sup_sync3 <= 1'b0;
            st_ff.sup_q     <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // open-drain: enable pulls low, never drives high
    assign cpu_reset_od_out.in   = cpu_reset_n_in;
    assign cpu_reset_od_out.oe   = st_ff.hold;           // [RULE4]
    assign cpu_halt_od_out.in    = cpu_halt_n_in;
    assign cpu_halt_od_out.oe    = st_ff.hold;           // [RULE4]
    assign ext_reset_n_out       = ~st_ff.ext_hold;
    assign power_mon_n_out       = ~st_ff.pmon_low;
    assign failsafe_active_out   = st_ff.fs;
    assign failsafe_active_n_out = ~st_ff.fs;
    assign isolated_power_on_n_out = st_ff.iso_on_n;
    assign xcvr_tx_en_out        = st_ff.tx_en;

    // helper: cycles of continuous external hold
    logic [5:0] ext_run_ff;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_run_ff <= 6'h00;
        end else if (!st_ff.ext_hold) begin
            ext_run_ff <= 6'h00;
        end else if (ext_run_ff != 6'h3f) begin
            ext_run_ff <= ext_run_ff + 6'h01;
        end
    end

    // the counter holds the run length, saturated at 63, in the cycle the hold is seen low
    chk_ext_min_hold: assert property ( // [RULE2]
        $fell(st_ff.ext_hold) |-> ext_run_ff >= EXT_CYC[5:0])
        else $error("external hold shorter than 24 cycles");
    chk_hold_od: assert property ( // [RULE4]
        st_ff.hold |-> cpu_reset_od_out.oe && cpu_halt_od_out.oe)
        else $error("reset or halt not pulled while holding");
    chk_brownout_low: assert property ( // [RULE3]
        !st_ff.sup_q |=> st_ff.hold && st_ff.pmon_low && st_ff.cnt == HOLD_LD)
        else $error("brown-out did not reload hold");
    chk_pwr_release: assert property ( // [RULE1]
        $fell(st_ff.hold) && $past(st_ff.state) == RSTFS_ST_PWR
        |-> $past(st_ff.cnt) == CNT_ONE)
        else $error("power-on hold released early");
    chk_pwr_not_cut: assert property ( // [RULE1]
        st_ff.state == RSTFS_ST_PWR && st_ff.cnt >= EXT_CYC
        |=> st_ff.state == RSTFS_ST_PWR)
        else $error("power-on hold cut short");
    chk_wdog_sets: assert property ( // [RULE5]
        !wdog_sync_n && st_ff.state == RSTFS_ST_RUN |=> st_ff.fs)
        else $error("watchdog did not set latch");
    chk_latch_stays: assert property ( // [RULE7]
        st_ff.fs && ext_sync_n && st_ff.sup_q |=> st_ff.fs)
        else $error("latch cleared without reset");
    chk_safe_outs: assert property ( // [RULE6]
        st_ff.fs |-> st_ff.iso_on_n && !st_ff.tx_en)
        else $error("fail-safe outputs not forced");
    chk_iso_wait: assert property ( // [RULE8]
        st_ff.hold |=> isolated_power_on_n_out)
        else $error("isolated power on during reset");
    chk_rx_dir: assert property ( // [RULE9]
        failsafe_active_out |-> !xcvr_tx_en_out)
        else $error("transmit enabled in fail-safe");

    cov_ext_reset: cover property ($fell(st_ff.ext_hold));
    cov_pwr_release: cover property (
        $fell(st_ff.hold) && $past(st_ff.state) == RSTFS_ST_PWR);
    cov_failsafe: cover property ($rose(st_ff.fs));
endmodule // rstfs_top
`default_nettype wire

// [rtl/rstfs_pkg.sv]
// package: constants and carrier types for the reset and fail-safe block
package rstfs_pkg;
    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned HOLD_MS         = 130;
    localparam int unsigned HOLD_CYC        = HOLD_MS * 1000 * CLK_MHZ;
    localparam int unsigned EXT_MIN_CLKS    = 24;
    localparam int unsigned CNT_W           = 25;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 25'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE    = 25'h0000001;
    localparam logic [CNT_W-1:0] EXT_CYC    = 25'h0000018;

    // open-drain pin: level seen, drive enable (drive is always low)
    typedef struct packed {
        logic in;
        logic oe;
    } rstfs_od_t;

    typedef enum logic [1:0] {
        RSTFS_ST_PWR  = 2'b00,
        RSTFS_ST_EXT  = 2'b01,
        RSTFS_ST_RUN  = 2'b10
    } rstfs_state_t;
endpackage : rstfs_pkg

// [rtl/rstfs_sync3.sv]
// three-flop input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rstfs_sync3 (
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic async_in,
    output logic      sync_out
);
    import rstfs_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } rstfs_sync_t;

    rstfs_sync_t st_ff;
    rstfs_sync_t nxt_st;

    // s1 feeds only s2; q moves only when s2 and s3 match
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.q = st_ff.s3;
        end
    end

    // reset to one: all four inputs it filters are active-low, idle high
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= 4'hf;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.q;
endmodule // rstfs_sync3
`default_nettype wire

// [verification/rstfs_cpu_model.sv]
// processor stand-in: wired reset and halt lines, watchdog, transmit enable
`timescale 1ns/1ps
`default_nettype none
module rstfs_cpu_model (
    input  wire rstfs_pkg::rstfs_od_t reset_od_in,
    input  wire rstfs_pkg::rstfs_od_t halt_od_in,
    input  wire logic                 sys_clk_in,
    input  wire logic                 trip_in,
    output logic                      cpu_reset_n_out,
    output logic                      cpu_halt_n_out,
    output var logic                  watchdog_expired_n_out,
    output var logic                  tx_en_n_out
);
    import rstfs_pkg::*;
    // pulled-up shared wires, low while the block pulls them
    assign cpu_reset_n_out = ~reset_od_in.oe;
    assign cpu_halt_n_out  = ~halt_od_in.oe;
    // a live processor trips its watchdog low on command
    always @(posedge sys_clk_in) begin
        watchdog_expired_n_out <= ~(trip_in & cpu_reset_n_out);
        tx_en_n_out            <= ~cpu_reset_n_out; // wants to send once out
    end
endmodule // rstfs_cpu_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the reset and fail-safe block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rstfs_pkg::*;
    localparam int unsigned H = 100; // shortened hold keeps the run short
    logic sys_clk = 1'b0, rst_b = 1'b0, supply = 1'b0, trip = 1'b0;
    logic sel = 1'b0, sreset = 1'b0, take = 1'b0;
    wire logic wd_n, tx_n, cpu_rst_n, cpu_halt_n;
    rstfs_od_t rst_od, halt_od;
    logic ext_n, mon_n, fs, fs_n, iso_n, tx_en;
    wire logic [7:0] st;
    logic [7:0] exp_q[$];
    int miscompares = 0, checks_done = 0, n = 0, k = 0;
    assign st = {rst_od.oe, halt_od.oe, ext_n, mon_n, fs, fs_n, iso_n, tx_en};
    initial forever #4 sys_clk = ~sys_clk;
    rstfs_top #(.HOLD_CYCLES(H)) DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
        .supply_good_in(supply), .slot_select_in(sel),
        .slot_reset_in(sreset), .watchdog_expired_n_in(wd_n),
        .cpu_tx_en_n_in(tx_n), .cpu_reset_n_in(cpu_rst_n),
        .cpu_halt_n_in(cpu_halt_n), .cpu_reset_od_out(rst_od),
        .cpu_halt_od_out(halt_od), .ext_reset_n_out(ext_n),
        .power_mon_n_out(mon_n), .failsafe_active_out(fs),
        .failsafe_active_n_out(fs_n), .isolated_power_on_n_out(iso_n),
        .xcvr_tx_en_out(tx_en));
    rstfs_cpu_model cpu (.reset_od_in(rst_od), .halt_od_in(halt_od),
        .sys_clk_in(sys_clk), .trip_in(trip), .cpu_reset_n_out(cpu_rst_n),
        .cpu_halt_n_out(cpu_halt_n), .watchdog_expired_n_out(wd_n),
        .tx_en_n_out(tx_n));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic compare_status(input logic [7:0] e);
        checks_done++;
        if (st !== e || rst_od.in !== ~e[7] || halt_od.in !== ~e[6]) begin
            miscompares++;
            $display("CHECK FAILED %0t status %h want %h", $time, st, e);
        end
    endtask
    task automatic compare_min(input int got, input int lo);
        checks_done++;
        if (got < lo) begin
            miscompares++;
            $display("CHECK FAILED %0t held %0d want %0d", $time, got, lo);
        end
    endtask
    // oldest note is compared at the falling edge, once outputs settle
    always @(negedge sys_clk) if (take && exp_q.size() > 0)
        compare_status(exp_q.pop_front());
    task automatic expect_now(input logic [7:0] e);
        exp_q.push_back(e);
        take <= 1'b1;
        @(posedge sys_clk);
        take <= 1'b0;
    endtask
    // bounded wait for one status bit; a hang counts as a mismatch
    task automatic wait_for(input int b, input logic v, output int c);
        c = 0;
        while (st[b] !== v) begin
            @(negedge sys_clk);
            c++;
            if (c > 2000) begin
                miscompares++;
                $display("CHECK FAILED %0t wait on bit %0d", $time, b);
                report_and_stop();
            end
        end
        @(posedge sys_clk);
    endtask
    task automatic back_to_run();
        wait_for(7, 1'b0, n);
        wait_for(1, 1'b0, n);
        compare_min(n, 1);
        repeat (4) @(posedge sys_clk);
        expect_now(8'h35);
    endtask
    task automatic power_up();
        rst_b  <= 1'b0;
        supply <= 1'b0;
        repeat (2) @(posedge sys_clk);
        expect_now(8'he6);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        supply <= 1'b1;
        wait_for(7, 1'b0, n);
        compare_min(n, H);
        back_to_run();
    endtask
    // host asks for a hardware reset with select and reset together
    task automatic ext_reset();
        sel    <= 1'b1;
        sreset <= 1'b1;
        k = 2 + $urandom % 7;
        wait_for(5, 1'b0, n);
        repeat (k) @(posedge sys_clk);
        expect_now(8'hd6);
        sel    <= 1'b0;
        sreset <= 1'b0;
        wait_for(5, 1'b1, n);
        compare_min(n, EXT_MIN_CLKS);
        back_to_run();
    endtask
    task automatic trip_fs();
        trip <= 1'b1;
        wait_for(3, 1'b1, n);
        repeat (2) @(posedge sys_clk);
        expect_now(8'h3a);
        trip <= 1'b0;
        repeat (3 + $urandom % 20) @(posedge sys_clk);
        expect_now(8'h3a);
    endtask
    initial begin
        void'($urandom(14));
        power_up();
        sel <= 1'b1; // select alone is no reset request
        repeat (10) @(posedge sys_clk);
        expect_now(8'h35);
        sel <= 1'b0;
        @(posedge sys_clk);
        ext_reset();
        trip_fs();
        power_up(); // power-on reset clears the latch
        trip_fs();
        ext_reset(); // external reset clears the latch
        supply <= 1'b0; // brown-out
        wait_for(4, 1'b0, n);
        repeat (3) @(posedge sys_clk);
        expect_now(8'he6);
        supply <= 1'b1;
        wait_for(7, 1'b0, n);
        compare_min(n, H);
        back_to_run();
        repeat (2) @(posedge sys_clk);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
